// *** hw/psw_status_word.sv ***
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "psw_cfg.svh"
module psw_status_word
    import psw_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // alu side
    input  wire psw_op_t    alu_op,
    input  wire logic [7:0] alu_a,
    input  wire logic [7:0] alu_b,
    input  wire logic       alu_use_carry,
    input  wire logic       bit_operand,
    input  wire logic [7:0] acc_value,
    // flag outputs
    output logic            carry_flag,
    output logic            half_carry_flag,
    output logic            signed_wrap_flag,
    output logic            parity_flag,
    output logic            user_flag_zero,
    output logic            user_flag_one,
    output logic      [4:0] bank_base
);
    // ==========================================
    // arithmetic
    logic [7:0] word_reg;
    logic [7:0] word_next;
    logic       cin;
    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;
    logic       wr_hit;
    logic       rd_hit;
    logic       bit_res;
    logic       is_bit_op;

    // carry chain split so nibble and bit-6 carries are visible
    assign cin      = alu_use_carry & word_reg[`PSW_BIT_CARRY];
    assign low_sum  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
    assign low7_sum = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, cin};
    assign full_sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, cin};
    assign wr_hit   = reg_wr & (reg_addr == `PSW_ADDR_STATUS_WORD);
    assign rd_hit   = reg_rd & (reg_addr == `PSW_ADDR_STATUS_WORD);
    assign is_bit_op = (alu_op == PSW_OP_BIT_LOAD) | (alu_op == PSW_OP_BIT_AND)
                     | (alu_op == PSW_OP_BIT_OR) | (alu_op == PSW_OP_BIT_CPL);

    // boolean processor result on the carry flag
    always_comb begin
        case (alu_op)
            PSW_OP_BIT_LOAD: bit_res = bit_operand; // [RQ2]
            PSW_OP_BIT_AND:  bit_res = word_reg[`PSW_BIT_CARRY] & bit_operand; // [RQ2]
            PSW_OP_BIT_OR:   bit_res = word_reg[`PSW_BIT_CARRY] | bit_operand; // [RQ2]
            PSW_OP_BIT_CPL:  bit_res = ~word_reg[`PSW_BIT_CARRY]; // [RQ2]
            default:         bit_res = word_reg[`PSW_BIT_CARRY];
        endcase
    end

    // next word; software write wins over a same-cycle alu update
    always_comb begin
        word_next = word_reg;
        if (wr_hit) begin
            word_next = reg_wdata; // [RQ8]
        end else if (alu_op == PSW_OP_ADD) begin
            word_next[`PSW_BIT_CARRY]       = full_sum[8]; // [RQ1]
            word_next[`PSW_BIT_HALF_CARRY]  = low_sum[4]; // [RQ3]
            word_next[`PSW_BIT_SIGNED_WRAP] = full_sum[8] ^ low7_sum[7]; // [RQ6]
        end else if (is_bit_op) begin
            word_next[`PSW_BIT_CARRY] = bit_res; // [RQ2]
        end
        // user flags and bank bits untouched by alu paths [RQ4]
        word_next[`PSW_BIT_PARITY] = ^acc_value; // [RQ7]
    end

    // ==========================================
    // state and outputs, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_reg  <= `PSW_RESET_VALUE;
            reg_rdata <= 8'h00;
        end else begin
            word_reg  <= word_next;
            reg_rdata <= rd_hit ? word_reg : 8'h00;
        end
    end

    assign carry_flag       = word_reg[`PSW_BIT_CARRY];
    assign half_carry_flag  = word_reg[`PSW_BIT_HALF_CARRY];
    assign signed_wrap_flag = word_reg[`PSW_BIT_SIGNED_WRAP];
    assign parity_flag      = word_reg[`PSW_BIT_PARITY]; // parity lags acc by one cycle
    assign user_flag_zero   = word_reg[`PSW_BIT_USER_ZERO];
    assign user_flag_one    = word_reg[`PSW_BIT_USER_ONE];
    // bank base = select * 8 [RQ5]
    assign bank_base = {word_reg[`PSW_BIT_BANK_HIGH], word_reg[`PSW_BIT_BANK_LOW], 3'h0};

    // ==========================================
    // checks
    property p_carry_add;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit) |=> carry_flag == $past(full_sum[8]);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("carry wrong after add"); // [RQ1]
    property p_bit_and;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_BIT_AND && !wr_hit) |=> carry_flag == ($past(carry_flag) & $past(bit_operand));
    endproperty
    a_bit_and: assert property (p_bit_and) else $error("bit and result wrong"); // [RQ2]
    property p_half;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a[3:0] == 4'hF && alu_b[3:0] != 4'h0)
        |=> half_carry_flag;
    endproperty
    a_half: assert property (p_half) else $error("half carry missed"); // [RQ3]
    property p_user;
        @(posedge clk) disable iff (rst)
        !wr_hit |=> $stable(user_flag_zero) && $stable(user_flag_one) && $stable(bank_base);
    endproperty
    a_user: assert property (p_user) else $error("user flag or bank changed without write"); // [RQ4]
    property p_bank;
        @(posedge clk) disable iff (rst)
        wr_hit |=> bank_base == ($past(reg_wdata[4:3]) * 5'h08);
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong"); // [RQ5]
    property p_wrap;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a == 8'h7F && alu_b == 8'h01)
        |=> signed_wrap_flag && !carry_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("signed wrap missed"); // [RQ6]
    property p_parity;
        @(posedge clk) disable iff (rst)
        1'b1 |=> parity_flag == ^$past(acc_value);
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong"); // [RQ7]
    property p_write;
        @(posedge clk) disable iff (rst)
        wr_hit |=> word_reg[7:1] == $past(reg_wdata[7:1]);
    endproperty
    a_write: assert property (p_write) else $error("write not stored"); // [RQ8]

    // ==========================================
    // further checks, one per corner of each flag rule

    // an idle cycle must not disturb the carry
    property p_carry_idle;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_NONE && !wr_hit) |=> $stable(carry_flag);
    endproperty
    a_carry_idle: assert property (p_carry_idle) else $error("carry moved while idle"); // [RQ1]

    // zero plus anything below 100h can never carry
    property p_carry_clear;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a == 8'h00) |=> !carry_flag;
    endproperty
    a_carry_clear: assert property (p_carry_clear) else $error("carry set without carry out"); // [RQ1]

    // largest byte plus one wraps and must carry
    property p_carry_set;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && alu_a == 8'hFF && alu_b == 8'h01) |=> carry_flag;
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry out missed"); // [RQ1]

    // old carry fed back as carry-in completes the wrap
    property p_carry_in;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && alu_use_carry && carry_flag && alu_a == 8'hFF && alu_b == 8'h00)
        |=> carry_flag;
    endproperty
    a_carry_in: assert property (p_carry_in) else $error("carry-in ignored"); // [RQ1]

    // bit load copies the operand into the carry
    property p_bit_load;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_BIT_LOAD && !wr_hit) |=> carry_flag == $past(bit_operand);
    endproperty
    a_bit_load: assert property (p_bit_load) else $error("bit load result wrong"); // [RQ2]

    // bit or merges operand into the carry
    property p_bit_or;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_BIT_OR && !wr_hit) |=> carry_flag == ($past(carry_flag) | $past(bit_operand));
    endproperty
    a_bit_or: assert property (p_bit_or) else $error("bit or result wrong"); // [RQ2]

    // complement always flips the carry
    property p_bit_cpl;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_BIT_CPL && !wr_hit) |=> carry_flag != $past(carry_flag);
    endproperty
    a_bit_cpl: assert property (p_bit_cpl) else $error("bit complement wrong"); // [RQ2]

    // bit ops only touch the carry, arithmetic flags stay
    property p_bit_keep;
        @(posedge clk) disable iff (rst)
        (is_bit_op && !wr_hit) |=> $stable(half_carry_flag) && $stable(signed_wrap_flag);
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("bit op touched other flags"); // [RQ2]

    // low nibble of zero cannot carry into the high nibble
    property p_half_clear;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a[3:0] == 4'h0) |=> !half_carry_flag;
    endproperty
    a_half_clear: assert property (p_half_clear) else $error("half carry set falsely"); // [RQ3]

    // nibble sum above 0Fh, worked out independently of the adder
    property p_half_exact;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit)
        |=> half_carry_flag == (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}
                                 + {4'h0, $past(cin)}) > 5'h0F);
    endproperty
    a_half_exact: assert property (p_half_exact) else $error("half carry mismatch"); // [RQ3]

    // carry-in alone can push a full nibble over
    property p_half_cin;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && alu_use_carry && carry_flag && alu_a[3:0] == 4'hF)
        |=> half_carry_flag;
    endproperty
    a_half_cin: assert property (p_half_cin) else $error("half carry from carry-in missed"); // [RQ3]

    // idle cycles leave the half carry alone
    property p_half_idle;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_NONE && !wr_hit) |=> $stable(half_carry_flag);
    endproperty
    a_half_idle: assert property (p_half_idle) else $error("half carry moved while idle"); // [RQ3]

    // software owns the user flags
    property p_user_write;
        @(posedge clk) disable iff (rst)
        wr_hit |=> user_flag_zero == $past(reg_wdata[5]) && user_flag_one == $past(reg_wdata[1]);
    endproperty
    a_user_write: assert property (p_user_write) else $error("user flag write lost"); // [RQ4]

    // top bank sits at 18h
    property p_bank_top;
        @(posedge clk) disable iff (rst)
        (wr_hit && reg_wdata[4:3] == 2'h3) |=> bank_base == 5'h18;
    endproperty
    a_bank_top: assert property (p_bank_top) else $error("bank three base wrong"); // [RQ5]

    // bottom bank sits at 00h
    property p_bank_zero;
        @(posedge clk) disable iff (rst)
        (wr_hit && reg_wdata[4:3] == 2'h0) |=> bank_base == 5'h00;
    endproperty
    a_bank_zero: assert property (p_bank_zero) else $error("bank zero base wrong"); // [RQ5]

    // two negatives that give a positive: carry out set, wrap set
    property p_wrap_neg;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a == 8'h80 && alu_b == 8'h80)
        |=> signed_wrap_flag && carry_flag;
    endproperty
    a_wrap_neg: assert property (p_wrap_neg) else $error("negative wrap missed"); // [RQ6]

    // small positives never wrap
    property p_wrap_none;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit && !alu_use_carry && alu_a == 8'h01 && alu_b == 8'h01)
        |=> !signed_wrap_flag;
    endproperty
    a_wrap_none: assert property (p_wrap_none) else $error("wrap set falsely"); // [RQ6]

    // sign rule: like signs in, other sign out
    property p_wrap_sign;
        @(posedge clk) disable iff (rst)
        (alu_op == PSW_OP_ADD && !wr_hit)
        |=> signed_wrap_flag == (($past(alu_a[7]) == $past(alu_b[7])) && ($past(full_sum[7]) != $past(alu_a[7])));
    endproperty
    a_wrap_sign: assert property (p_wrap_sign) else $error("wrap disagrees with sign rule"); // [RQ6]

    // a written parity bit is ignored
    property p_parity_write;
        @(posedge clk) disable iff (rst)
        wr_hit |=> parity_flag == ^$past(acc_value);
    endproperty
    a_parity_write: assert property (p_parity_write) else $error("written parity kept"); // [RQ8]

    // software write beats a same-cycle add
    property p_write_wins;
        @(posedge clk) disable iff (rst)
        (wr_hit && alu_op == PSW_OP_ADD) |=> carry_flag == $past(reg_wdata[7]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("alu beat software write"); // [RQ8]

    // read data is the word as it stood at the strobe
    property p_read_data;
        @(posedge clk) disable iff (rst)
        rd_hit |=> reg_rdata == $past(word_reg);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong"); // [RQ8]

    // read data only stands for one cycle, zero otherwise
    property p_read_idle;
        @(posedge clk) disable iff (rst)
        !rd_hit |=> reg_rdata == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read"); // [RQ8]
endmodule : psw_status_word

// *** hw/psw_cfg.svh ***
// What this block does
// (RQ1) Carry flag, bit 7, follows the ALU carry out of its top bit.
// (RQ2) Carry flag is the one-bit operand and result of Boolean bit instructions.
// (RQ3) Half carry flag, bit 6, set on carry from low nibble into high nibble.
// (RQ4) User flags in bits 5 and 1 change only by software.
// (RQ5) Bank select bits 4:3 pick register bank base 00h, 08h, 10h or 18h.
// (RQ6) Signed wrap flag, bit 2, set when carry into and out of top bit differ.
// (RQ7) Parity flag, bit 0, always shows odd parity of the accumulator; the register lags the accumulator by one clock.
// (RQ8) Software write updates every bit except parity, which follows the accumulator.
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH
// ==========================================
// register map and fields
`define PSW_ADDR_STATUS_WORD 8'hD0
`define PSW_BIT_CARRY        7
`define PSW_BIT_HALF_CARRY   6
`define PSW_BIT_USER_ZERO    5
`define PSW_BIT_BANK_HIGH    4
`define PSW_BIT_BANK_LOW     3
`define PSW_BIT_SIGNED_WRAP  2
`define PSW_BIT_USER_ONE     1
`define PSW_BIT_PARITY       0
`define PSW_RESET_VALUE      8'h00
`define PSW_BANK_STRIDE      5'h08
`endif

// *** hw/psw_pkg.sv ***
package psw_pkg;
    // ==========================================
    // ALU operation kinds that touch the status word
    typedef enum logic [2:0] {
        PSW_OP_NONE,
        PSW_OP_ADD,
        PSW_OP_BIT_LOAD,
        PSW_OP_BIT_AND,
        PSW_OP_BIT_OR,
        PSW_OP_BIT_CPL
    } psw_op_t;
endpackage : psw_pkg

// *** testbench/psw_alu_model.sv ***
`timescale 1ns/1ns
module psw_alu_model
    import psw_pkg::*;
(
    // instruction kind, codes 6 and 7 act as idle
    input  wire logic [2:0] kind,
    // decoded operation
    output psw_op_t         alu_op
);
    // unused codes fall back to idle so the word never sees an illegal op
    assign alu_op = (kind > 3'h5) ? PSW_OP_NONE : psw_op_t'(kind);
endmodule : psw_alu_model

// *** testbench/psw_status_word_tb_top.sv ***
`timescale 1ns/1ns
module psw_status_word_tb_top;
    import psw_pkg::*;
    // ==========================================
    // stimulus and observation
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, alu_use_carry = 0, bit_operand = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, acc_value = 8'h00;
    logic [7:0] e = 8'h00, reg_rdata;
    logic [2:0] kind = 3'h0;
    logic [4:0] bank_base;
    logic [15:0] x;
    logic carry_flag, half_carry_flag, signed_wrap_flag, parity_flag, user_flag_zero, user_flag_one;
    psw_op_t alu_op;
    logic [15:0] q[$];
    integer seed = 83, bad_count = 0, n_tests = 0, i, ra, rb;
    always #25 clk = ~clk;
    psw_alu_model alu (.kind, .alu_op);
    psw_status_word uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alu_op, .alu_a,
        .alu_b, .alu_use_carry, .bit_operand, .acc_value, .carry_flag, .half_carry_flag, .signed_wrap_flag,
        .parity_flag, .user_flag_zero, .user_flag_one, .bank_base);
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // one bus and alu cycle; the expected word is kept here, write wins over alu
    task step(input logic [2:0] k, input logic [7:0] a, b, acc, ad, wd, input logic w, r, c, bt);
        logic [8:0] s;
        logic [7:0] s7, rx;
        logic [4:0] h;
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {ad, wd, w, r};
        {kind, alu_a, alu_b, alu_use_carry, bit_operand, acc_value} <= {k, a, b, c, bt, acc};
        rx = (r && ad == 8'hD0) ? e : 8'h00;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c & e[7]};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c & e[7]};
        s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c & e[7]};
        case (k)
            3'h1: {e[7], e[6], e[2]} = {s[8], h[4], s[8] ^ s7[7]};
            3'h2: e[7] = bt;
            3'h3: e[7] = e[7] & bt;
            3'h4: e[7] = e[7] | bt;
            3'h5: e[7] = ~e[7];
            default: ;
        endcase
        if (w && ad == 8'hD0) e = wd;
        e[0] = ^acc;
        q.push_back({rx, e});
    endtask : step
    // the oldest note is due once a newer one has been queued
    always @(negedge clk) begin
        if (q.size() > 1) begin
            x = q.pop_front();
            chk({7'h00, carry_flag}, {7'h00, x[7]});
            chk({7'h00, half_carry_flag}, {7'h00, x[6]});
            chk({6'h00, user_flag_zero, user_flag_one}, {6'h00, x[5], x[1]});
            chk({3'h0, bank_base}, {3'h0, x[4:3], 3'h0});
            chk({7'h00, signed_wrap_flag}, {7'h00, x[2]});
            chk({7'h00, parity_flag}, {7'h00, x[0]});
            chk(reg_rdata, x[15:8]);
        end
    end
    // ==========================================
    // directed walk then random traffic
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk) step(3'h1, 8'h7F, 8'h01, 8'h01, 8'hD0, 8'hFF, 0, 0, 0, 0);
        @(posedge clk) step(3'h1, 8'h80, 8'h80, 8'h03, 8'hD0, 8'hFF, 1, 0, 1, 0);
        @(posedge clk) step(3'h5, 8'h00, 8'h00, 8'h07, 8'hD0, 8'h00, 0, 1, 0, 0);
        for (i = 0; i < 600; i++) begin
            ra = $random(seed);
            rb = $random(seed);
            @(posedge clk) step(ra[2:0], ra[10:3], ra[18:11], ra[26:19], rb[0] ? 8'hD0 : rb[8:1], rb[16:9],
                rb[17], ~rb[17] & rb[18], rb[19], rb[20]);
        end
        @(posedge clk) step(3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0);
        repeat (3) @(posedge clk);
        wrap_up;
    end
    // watchdog, about five times the expected run
    initial begin
        #160000;
        bad_count++;
        wrap_up;
    end
endmodule : psw_status_word_tb_top
